// File: ced_comp_model.sv
module ced_comp_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // bench level, adc side
  input wire logic lvl,
  input wire logic adc_trigger,
  // comparator side, pulse tally
  output logic comp_out,
  output logic [15:0] trig_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  assign comp_out = lvl;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trig_cnt <= 16'h0;
    end else if (adc_trigger) begin
      trig_cnt <= trig_cnt + 16'h1;
    end
  end
endmodule : ced_comp_model

// File: ced_pkg.sv
package ced_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] CED_CTRL_OFS = 12'h024;
  localparam logic [11:0] CED_STAT_OFS = 12'h020;
  localparam logic [11:0] CED_RIS_OFS = 12'h000;
  localparam logic [11:0] CED_IMASK_OFS = 12'h004;
  localparam logic [31:0] CED_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] CED_MASK_RST = 2'h0;

  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int CED_FWD_EN_POS = 11;
  localparam int CED_TRG_LVL_POS = 7;
  localparam int CED_TRG_SENSE_POS = 5;
  localparam int CED_IRQ_LVL_POS = 4;
  localparam int CED_IRQ_SENSE_POS = 2;
  localparam int CED_INV_POS = 1;
  localparam logic [31:0] CED_CTRL_WMASK = 32'h0000_08fe;

  // ----------------------------------------
  // status bit positions
  // ----------------------------------------
  localparam int CED_ST_IRQ_POS = 0;
  localparam int CED_ST_TRG_POS = 1;

  // ----------------------------------------
  // sense modes
  // ----------------------------------------
  localparam logic [1:0] CED_SENSE_LEVEL = 2'h0;
  localparam logic [1:0] CED_SENSE_FALL = 2'h1;
  localparam logic [1:0] CED_SENSE_RISE = 2'h2;
  localparam logic [1:0] CED_SENSE_BOTH = 2'h3;

  typedef struct packed {
    logic adc_trigger_forward_enable;
    logic adc_trigger_active_level;
    logic [1:0] adc_trigger_sense_select;
    logic irq_active_level;
    logic [1:0] irq_sense_select;
    logic comparator_output_invert;
  } ced_cfg_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } ced_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ced_apb_rsp_t;

endpackage : ced_pkg

// File: ced_sense.sv
module ced_sense (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // conditioned comparator level
  input wire logic cond_in,
  // sense configuration
  input wire logic [1:0] sense_select,
  input wire logic active_level,
  // qualified event, combinational
  output logic event_hit
);
  import ced_pkg::*;

  logic prev_r;
  logic rise;
  logic fall;

  // previous-cycle sample for edge compare
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= cond_in;
    end
  end

  assign rise = cond_in & ~prev_r;
  assign fall = ~cond_in & prev_r;

  always_comb begin
    case (sense_select)
      CED_SENSE_LEVEL: event_hit = (cond_in == active_level);
      CED_SENSE_FALL: event_hit = fall;
      CED_SENSE_RISE: event_hit = rise;
      CED_SENSE_BOTH: event_hit = rise | fall;
      default: event_hit = 1'b0;
    endcase
  end

endmodule : ced_sense

// File: ced_sync.sv
module ced_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // asynchronous level in, synchronised level out
  input wire logic d_async,
  output logic q_sync
);
  import ced_pkg::*;

  logic meta_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      q_sync <= 1'b0;
    end else begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end

endmodule : ced_sync

// File: ced_top.sv
// Operation
// - trigger sense 1 falling, 2 rising, 3 either edge makes an ADC event
// - trigger sense 0 uses level sensing with the trigger level bit
// - interrupt sense 1 falling, 2 rising, 3 either edge raises interrupt
// - interrupt sense 0 uses level sensing with the interrupt level bit
// - interrupt level 0 fires while output low, 1 while output high
// - invert bit set inverts comparator output before all processing
// - trigger level 0 fires while output low, 1 while output high
// - forward enable 0 suppresses ADC events, 1 forwards them
module ced_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog comparator
  input wire logic comp_out,
  // adc and interrupt
  output logic adc_trigger,
  output logic irq
);
  import ced_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  ced_cfg_t cfg_r;
  logic [1:0] sticky_r;
  logic [1:0] sticky_nxt;
  logic [1:0] mask_r;
  logic comp_sync;
  logic cond_lvl;
  logic irq_hit;
  logic trg_hit;
  logic acc;
  logic wr_acc;
  logic [31:0] rd_mux;
  logic rd_err;
  logic [31:0] ctrl_view;

  function automatic logic [31:0] ced_pack_cfg(input ced_cfg_t c);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[CED_FWD_EN_POS] = c.adc_trigger_forward_enable;
    v[CED_TRG_LVL_POS] = c.adc_trigger_active_level;
    v[CED_TRG_SENSE_POS +: 2] = c.adc_trigger_sense_select;
    v[CED_IRQ_LVL_POS] = c.irq_active_level;
    v[CED_IRQ_SENSE_POS +: 2] = c.irq_sense_select;
    v[CED_INV_POS] = c.comparator_output_invert;
    return v;
  endfunction : ced_pack_cfg

  function automatic ced_cfg_t ced_unpack_cfg(input logic [31:0] v);
    ced_cfg_t c;
    c.adc_trigger_forward_enable = v[CED_FWD_EN_POS];
    c.adc_trigger_active_level = v[CED_TRG_LVL_POS];
    c.adc_trigger_sense_select = v[CED_TRG_SENSE_POS +: 2];
    c.irq_active_level = v[CED_IRQ_LVL_POS];
    c.irq_sense_select = v[CED_IRQ_SENSE_POS +: 2];
    c.comparator_output_invert = v[CED_INV_POS];
    return c;
  endfunction : ced_unpack_cfg

  // reset image of the control fields, a constant for the async reset branch
  localparam ced_cfg_t CED_CFG_RST = ced_unpack_cfg(CED_CTRL_RST);

  // ----------------------------------------
  // comparator input conditioning
  // ----------------------------------------
  ced_sync u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d_async(comp_out),
    .q_sync(comp_sync)
  );

  assign cond_lvl = comp_sync ^ cfg_r.comparator_output_invert;

  ced_sense u_irq_sense (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cond_in(cond_lvl),
    .sense_select(cfg_r.irq_sense_select),
    .active_level(cfg_r.irq_active_level),
    .event_hit(irq_hit)
  );

  ced_sense u_trg_sense (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cond_in(cond_lvl),
    .sense_select(cfg_r.adc_trigger_sense_select),
    .active_level(cfg_r.adc_trigger_active_level),
    .event_hit(trg_hit)
  );

  // ----------------------------------------
  // adc trigger output
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      adc_trigger <= 1'b0;
    end else begin
      adc_trigger <= trg_hit & cfg_r.adc_trigger_forward_enable;
    end
  end

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign acc = psel & penable;
  assign wr_acc = acc & pwrite;
  assign ctrl_view = ced_pack_cfg(cfg_r);

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      CED_CTRL_OFS: rd_mux = ctrl_view;
      CED_STAT_OFS: rd_mux = {30'h0, cond_lvl, 1'b0};
      CED_RIS_OFS: rd_mux = {30'h0, sticky_r};
      CED_IMASK_OFS: rd_mux = {30'h0, mask_r};
      default: rd_err = 1'b1;
    endcase
  end

  // zero-wait slave: pready high in every access cycle
  always_comb begin
    pready = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= rd_err;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= CED_CFG_RST;
    end else if (wr_acc && paddr == CED_CTRL_OFS) begin
      cfg_r <= ced_unpack_cfg(pwdata & CED_CTRL_WMASK);
    end
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mask_r <= CED_MASK_RST;
    end else if (wr_acc && paddr == CED_IMASK_OFS) begin
      mask_r <= pwdata[1:0];
    end
  end

  always_comb begin
    sticky_nxt = sticky_r;
    if (wr_acc && paddr == CED_RIS_OFS) begin
      sticky_nxt = sticky_r & ~pwdata[1:0];
    end
    // set wins over write-one-to-clear
    sticky_nxt[CED_ST_IRQ_POS] = sticky_nxt[CED_ST_IRQ_POS] | irq_hit;
    sticky_nxt[CED_ST_TRG_POS] = sticky_nxt[CED_ST_TRG_POS] | trg_hit;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sticky_r <= 2'h0;
      irq <= 1'b0;
    end else begin
      sticky_r <= sticky_nxt;
      irq <= |(sticky_nxt & mask_r);
    end
  end

endmodule : ced_top

// File: ced_top_sva.sv
module ced_top_sva
  import ced_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // apb and pins
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic comp_out,
  input wire logic adc_trigger,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic s1_r, s2_r, p_r, wr, ok, c, q, te, ie;
  logic [7:0] cf_r;
  logic [1:0] mk_r, st_r;
  function automatic logic hit(logic [1:0] s, logic l, logic a, logic b);
    case (s)
      2'h0: return a == l;
      2'h1: return b & ~a;
      2'h2: return ~b & a;
      default: return a ^ b;
    endcase
  endfunction : hit
  assign wr = psel & penable & pwrite;
  assign ok = st_r == 2'h0;
  assign c = s2_r ^ cf_r[0];
  assign q = p_r ^ cf_r[0];
  assign te = cf_r[7] & hit(cf_r[5:4], cf_r[6], c, q);
  assign ie = hit(cf_r[2:1], cf_r[3], c, q);
  // mirror of sync, config and mask; quiet after writes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {s1_r, s2_r, p_r, cf_r, mk_r, st_r} <= '0;
    end else begin
      {s1_r, s2_r, p_r} <= {comp_out, s1_r, s2_r};
      st_r <= wr ? 2'h3 : (st_r == 2'h0 ? 2'h0 : st_r - 2'h1);
      if (wr && paddr == CED_CTRL_OFS) begin
        cf_r <= {pwdata[11], pwdata[7:1]};
      end
      if (wr && paddr == CED_IMASK_OFS) begin
        mk_r <= pwdata[1:0];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_TRG_EDGE: assert property (ok && cf_r[5:4] != 2'h0 |=> adc_trigger == $past(te))
    else $error("edge trigger wrong");
  AST_TRG_LVL: assert property (ok && cf_r[5:4] == 2'h0 |=> adc_trigger == $past(te))
    else $error("level trigger wrong");
  AST_TRG_GATE: assert property (ok && !cf_r[7] |=> !adc_trigger)
    else $error("trigger not gated");
  AST_INV: assert property (ok && cf_r[0] && cf_r[7] && cf_r[5:4] == 2'h0 && s2_r != cf_r[6]
    |=> adc_trigger)
    else $error("invert not applied");
  AST_IRQ_EDGE: assert property (ok && mk_r[0] && cf_r[2:1] != 2'h0 && ie |=> irq)
    else $error("edge irq missing");
  AST_IRQ_LVL: assert property (ok && mk_r[0] && cf_r[2:1] == 2'h0 && c == cf_r[3] |=> irq)
    else $error("level irq missing");
  AST_PULSE: assert property (ok && cf_r[7] && cf_r[5:4] != 2'h0 && s2_r == p_r
    |=> !adc_trigger)
    else $error("trigger without edge");
  AST_IRQ_MASK: assert property (ok && mk_r == 2'h0 |=> !irq)
    else $error("masked irq raised");
endmodule : ced_top_sva

bind ced_top ced_top_sva u_sva (.clk_sys, .rst_b, .paddr, .psel, .penable, .pwrite,
  .pwdata, .comp_out, .adc_trigger, .irq);

// File: ced_top_tb.sv
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h seen %0h", n, e, s); end end
module ced_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ced_pkg::*;
  logic clk_sys, rst_b, psel, penable, pwrite, lvl, comp_out, pready, pslverr, adc_trigger, irq;
  logic r, inv, en, lv, x, e;
  logic [1:0] ts;
  logic [11:0] paddr, cfg;
  logic [31:0] pwdata, prdata;
  logic [15:0] trig_cnt, c0, lx;
  logic [32:0] exq[$];
  logic [32:0] ex;
  int error_cnt, checks;
  ced_top dut (.clk_sys, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .comp_out, .adc_trigger, .irq);
  ced_comp_model u_cmp (.clk_sys, .rst_b, .lvl, .adc_trigger, .comp_out, .trig_cnt);
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    input logic [32:0] ev);
    if (!w) exq.push_back(ev);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  // --------------------------------
  // read monitor
  // --------------------------------
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      ex = exq.pop_front();
      `CHK("apb read", ex, {pslverr, prdata})
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (4000) @(posedge clk_sys);
    error_cnt++;
    close_out();
  end
  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, lvl, paddr, pwdata} = '0;
    void'($urandom(59295));
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    apb(CED_CTRL_OFS, 1'b0, 32'h0, {1'b0, CED_CTRL_RST});
    apb(CED_RIS_OFS, 1'b0, 32'h0, 33'h3);
    apb(12'h008, 1'b0, 32'h0, {1'b1, 32'h0});
    apb(CED_IMASK_OFS, 1'b1, 32'h1, 33'h0);
    $display("test regs done");
    for (int m = 0; m < 32; m++) begin
      r = 1'($urandom);
      {lv, en, inv, ts} = 5'(m);
      x = r ^ inv;
      cfg = {en, 3'h0, lv, ts, lv, ts, inv, 1'b0};
      e = (ts == 2'h3) | (ts == 2'h2 & !x) | (ts == 2'h1 & x);
      lx = (ts == 2'h0 && en && x == lv) ? 16'h8 : 16'h0;
      lvl <= r;
      apb(CED_CTRL_OFS, 1'b1, ($urandom & 32'hffff_f701) | {20'h0, cfg}, 33'h0);
      apb(CED_CTRL_OFS, 1'b0, 32'h0, {21'h0, cfg});
      repeat (6) @(posedge clk_sys);
      apb(CED_RIS_OFS, 1'b1, 32'h3, 33'h0);
      c0 = trig_cnt;
      repeat (8) @(posedge clk_sys);
      `CHK("level count", trig_cnt - c0, lx)
      c0 = trig_cnt;
      lvl <= ~r;
      repeat (12) @(posedge clk_sys);
      if (ts != 2'h0) `CHK("edge count", trig_cnt - c0, {15'h0, en & e})
      apb(CED_RIS_OFS, 1'b0, 32'h0, {31'h0, {2{ts == 2'h0 || e}}});
      apb(CED_STAT_OFS, 1'b0, 32'h0, {31'h0, ~x, 1'b0});
      `CHK("irq", irq, ts == 2'h0 || e)
      $display("test mode %0d done", m);
    end
    apb(CED_IMASK_OFS, 1'b1, 32'h0, 33'h0);
    repeat (2) @(posedge clk_sys);
    `CHK("irq masked", irq, 1'b0)
    $display("test mask done");
    close_out();
  end
endmodule : ced_top_tb
